// ---- design/sdalu_core.sv ----
// Purpose: execute stage for standard data-processing operations
// Assumes: decoder presents one operation per issue_valid cycle, same clock
// Notes: one-cycle latency; flags live here and persist between operations
`timescale 1ns/1ps
`default_nettype none
module sdalu_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire sdalu_pkg::sdalu_op_t op,
  input wire logic set_flags,
  input wire sdalu_pkg::sdalu_src_t src,
  input wire sdalu_pkg::sdalu_shift_t shift_type,
  input wire logic [4:0] shift_amount,
  input wire logic [11:0] imm12,
  input wire logic [15:0] imm16,
  input wire logic pc_subtract,
  input wire logic [3:0] dest_index,
  input wire logic [31:0] first_operand_register,
  input wire logic [31:0] second_operand_register,
  input wire logic [31:0] instr_address,
  output logic result_valid,
  output logic [31:0] result,
  output logic dest_write,
  output logic [3:0] dest_out,
  output logic [3:0] flags
);

  logic [31:0] shifted;
  logic shift_carry;
  logic [31:0] imm_value;
  logic imm_carry;
  logic [31:0] operand_b;
  logic operand_carry;
  logic [31:0] imm12_zext;
  logic [31:0] pc_aligned;
  logic [31:0] add_a;
  logic [31:0] add_b;
  logic add_cin;
  logic [32:0] sum;
  logic is_arith;
  logic is_flag_only;
  logic [31:0] result_next;
  logic write_next;
  logic flags_set_next;
  logic [3:0] flags_next;

  // shift amount is the instruction constant field, no register path exists
  sdalu_shifter u_shifter (
    .value(second_operand_register),
    .shift_type(shift_type),
    .amount(shift_amount),
    .carry_in(flags[sdalu_pkg::FLAG_C]),
    .shifted(shifted),
    .carry_out(shift_carry)
  );

  sdalu_immexp u_immexp (
    .imm12(imm12),
    .imm16(imm16),
    .src(src),
    .carry_in(flags[sdalu_pkg::FLAG_C]),
    .imm_value(imm_value),
    .imm_carry(imm_carry)
  );

  // second operand: shifted register or one of the immediate forms
  always_comb begin
    if (src == sdalu_pkg::SRC_SHIFTED_REG) begin
      operand_b = shifted;
      operand_carry = shift_carry;
    end else begin
      operand_b = imm_value;
      operand_carry = imm_carry;
    end
  end

  // pc-relative base; the decoder supplies the address, not the pc
  assign imm12_zext = {{(sdalu_pkg::DATA_W - sdalu_pkg::IMM12_W){1'b0}}, imm12};
  assign pc_aligned = (instr_address + sdalu_pkg::PC_STEP) & sdalu_pkg::PC_ALIGN_MASK;

  // one shared adder; subtraction is add of the inverse with carry in set, or with the carry flag as carry in for subtract with carry
  always_comb begin
    add_a = first_operand_register;
    add_b = operand_b;
    add_cin = 1'b0;
    is_arith = 1'b1;
    case (op)
      sdalu_pkg::OP_ADD, sdalu_pkg::OP_COMPARE_NEGATIVE: begin
        add_cin = 1'b0;
      end
      sdalu_pkg::OP_ADD_WITH_CARRY: begin
        add_cin = flags[sdalu_pkg::FLAG_C];
      end
      sdalu_pkg::OP_SUBTRACT, sdalu_pkg::OP_COMPARE: begin
        add_b = ~operand_b;
        add_cin = 1'b1;
      end
      sdalu_pkg::OP_SUBTRACT_WITH_CARRY: begin
        add_b = ~operand_b;
        add_cin = flags[sdalu_pkg::FLAG_C];
      end
      sdalu_pkg::OP_REVERSE_SUBTRACT: begin
        add_a = operand_b;
        add_b = ~first_operand_register;
        add_cin = 1'b1;
      end
      sdalu_pkg::OP_PC_RELATIVE: begin
        // operand is always the plain 12-bit field, whatever src says
        add_a = pc_aligned;
        add_b = pc_subtract ? ~imm12_zext : imm12_zext;
        add_cin = pc_subtract;
      end
      default: begin
        is_arith = 1'b0;
      end
    endcase
  end

  assign sum = {1'b0, add_a} + {1'b0, add_b} + {32'h0000_0000, add_cin};

  // operation result and write decision
  always_comb begin
    result_next = sum[31:0];
    write_next = 1'b1;
    is_flag_only = 1'b0;
    case (op)
      sdalu_pkg::OP_BITWISE_AND: result_next = first_operand_register & operand_b;
      sdalu_pkg::OP_BIT_CLEAR: result_next = first_operand_register & ~operand_b;
      sdalu_pkg::OP_EXCLUSIVE_OR: result_next = first_operand_register ^ operand_b;
      sdalu_pkg::OP_BITWISE_OR: result_next = first_operand_register | operand_b;
      sdalu_pkg::OP_OR_NOT: result_next = first_operand_register | ~operand_b;
      sdalu_pkg::OP_TEST_EQUIVALENCE: begin
        result_next = first_operand_register ^ operand_b;
        write_next = 1'b0;
        is_flag_only = 1'b1;
      end
      sdalu_pkg::OP_TEST_BITS: begin
        result_next = first_operand_register & operand_b;
        write_next = 1'b0;
        is_flag_only = 1'b1;
      end
      sdalu_pkg::OP_COMPARE, sdalu_pkg::OP_COMPARE_NEGATIVE: begin
        write_next = 1'b0;
        is_flag_only = 1'b1;
      end
      // a shifted-register copy is exactly the shift: value and carry from the shifter
      sdalu_pkg::OP_COPY_TO_DESTINATION: result_next = operand_b;
      sdalu_pkg::OP_BITWISE_NOT: result_next = ~operand_b;
      default: result_next = sum[31:0];
    endcase
  end

  // flags: compares and tests always set; pc-relative never touches them
  always_comb begin
    flags_set_next = (set_flags && op != sdalu_pkg::OP_PC_RELATIVE) || is_flag_only;
    flags_next = flags;
    if (flags_set_next) begin
      flags_next[sdalu_pkg::FLAG_N] = result_next[31];
      flags_next[sdalu_pkg::FLAG_Z] = (result_next == '0);
      if (is_arith) begin
        flags_next[sdalu_pkg::FLAG_C] = sum[32];
        flags_next[sdalu_pkg::FLAG_V] = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
      end else begin
        // logic ops leave overflow alone and take carry from the operand stage
        flags_next[sdalu_pkg::FLAG_C] = operand_carry;
      end
    end
  end

  // result pipeline stage; result is kept even when no write happens
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_valid <= 1'b0;
      result <= '0;
      dest_write <= 1'b0;
      dest_out <= '0;
    end else begin
      result_valid <= issue_valid;
      dest_write <= issue_valid && write_next;
      if (issue_valid) begin
        result <= result_next;
        dest_out <= dest_index;
      end
    end
  end

  // condition flags held across operations
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= sdalu_pkg::FLAGS_RESET;
    end else if (issue_valid) begin
      flags <= flags_next;
    end
  end

  property p_compare_no_write;
    @(posedge clk) disable iff (!resetn)
    issue_valid && (op == sdalu_pkg::OP_COMPARE || op == sdalu_pkg::OP_COMPARE_NEGATIVE)
      |=> result_valid && !dest_write
        && flags[sdalu_pkg::FLAG_Z] == (result == '0);
  endproperty
  a_compare_no_write: assert property (p_compare_no_write) else $error("compare wrote");

  property p_test_flags;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_TEST_BITS && src == sdalu_pkg::SRC_PLAIN_IMM16
      ##1 1'b1 |-> !dest_write
        && result == ($past(first_operand_register) & {16'h0000, $past(imm16)})
        && flags[sdalu_pkg::FLAG_N] == result[31];
  endproperty
  a_test_flags: assert property (p_test_flags) else $error("test result or flags wrong");

  property p_flags_kept;
    @(posedge clk) disable iff (!resetn)
    issue_valid && !set_flags && op != sdalu_pkg::OP_COMPARE
      && op != sdalu_pkg::OP_COMPARE_NEGATIVE && op != sdalu_pkg::OP_TEST_BITS
      && op != sdalu_pkg::OP_TEST_EQUIVALENCE |=> $stable(flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

  property p_add_flags;
    @(posedge clk) disable iff (!resetn)
    issue_valid && set_flags && op == sdalu_pkg::OP_ADD |=>
      flags[sdalu_pkg::FLAG_N] == result[31] && flags[sdalu_pkg::FLAG_Z] == (result == '0)
      && dest_write;
  endproperty
  a_add_flags: assert property (p_add_flags) else $error("add flags wrong");

  property p_reverse_subtract;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_REVERSE_SUBTRACT && src == sdalu_pkg::SRC_PLAIN_IMM12
      |=> result == {20'h00000, $past(imm12)} - $past(first_operand_register);
  endproperty
  a_reverse_subtract: assert property (p_reverse_subtract) else $error("rsb wrong");

  property p_pc_relative;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_PC_RELATIVE && !pc_subtract |=>
      result == ((($past(instr_address) + 32'h0000_0004) & 32'hffff_fffc)
        + {20'h00000, $past(imm12)}) && $stable(flags);
  endproperty
  a_pc_relative: assert property (p_pc_relative) else $error("pc-relative wrong");

  property p_right_shift_full;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_COPY_TO_DESTINATION
      && src == sdalu_pkg::SRC_SHIFTED_REG && shift_amount == 5'h00
      && shift_type == sdalu_pkg::SH_ARITHMETIC_SHIFT_RIGHT
      |=> result == {32{$past(second_operand_register[31])}};
  endproperty
  a_right_shift_full: assert property (p_right_shift_full) else $error("asr 32 wrong");

  property p_rotate_extend;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_COPY_TO_DESTINATION
      && src == sdalu_pkg::SRC_SHIFTED_REG && shift_amount == 5'h00
      && shift_type == sdalu_pkg::SH_ROTATE_RIGHT
      |=> result == {$past(flags[sdalu_pkg::FLAG_C]), $past(second_operand_register[31:1])};
  endproperty
  a_rotate_extend: assert property (p_rotate_extend) else $error("extend rotate wrong");

  property p_copy_shift_left;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_COPY_TO_DESTINATION
      && src == sdalu_pkg::SRC_SHIFTED_REG
      && shift_type == sdalu_pkg::SH_LOGICAL_SHIFT_LEFT
      |=> result == ($past(second_operand_register) << $past(shift_amount));
  endproperty
  a_copy_shift_left: assert property (p_copy_shift_left) else $error("copy shift wrong");

  property p_not_modified;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_BITWISE_NOT && src == sdalu_pkg::SRC_MODIFIED_IMM
      && imm12[11:8] == 4'h0
      |=> dest_write && result == ~{24'h000000, $past(imm12[7:0])};
  endproperty
  a_not_modified: assert property (p_not_modified) else $error("not of constant wrong");

  property p_add_plain;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_ADD && src == sdalu_pkg::SRC_PLAIN_IMM12 ##1 1'b1
      |-> result == $past(first_operand_register) + {20'h00000, $past(imm12)};
  endproperty
  a_add_plain: assert property (p_add_plain) else $error("plain add wrong");

  // held outputs move only on an accepted operation; the answer comes one edge later
  property p_idle_hold;
    @(posedge clk) disable iff (!resetn)
    !issue_valid |=> !result_valid && !dest_write && $stable(result) && $stable(flags);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle changed outputs");

  property p_issue_answer;
    @(posedge clk) disable iff (!resetn)
    issue_valid |=> result_valid && dest_out == $past(dest_index);
  endproperty
  a_issue_answer: assert property (p_issue_answer) else $error("answer missing");

  property p_test_equivalence;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_TEST_EQUIVALENCE |=> !dest_write
      && flags[sdalu_pkg::FLAG_N] == result[31] && flags[sdalu_pkg::FLAG_Z] == (result == '0);
  endproperty
  a_test_equivalence: assert property (p_test_equivalence) else $error("teq wrote");

  property p_right_shift_zero;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_COPY_TO_DESTINATION
      && src == sdalu_pkg::SRC_SHIFTED_REG && shift_amount == sdalu_pkg::AMT_ZERO
      && shift_type == sdalu_pkg::SH_LOGICAL_SHIFT_RIGHT |=> result == '0;
  endproperty
  a_right_shift_zero: assert property (p_right_shift_zero) else $error("lsr 32 wrong");

  property p_pc_subtract;
    @(posedge clk) disable iff (!resetn)
    issue_valid && op == sdalu_pkg::OP_PC_RELATIVE && pc_subtract |=>
      result == ((($past(instr_address) + 32'h0000_0004) & 32'hffff_fffc)
        - {20'h00000, $past(imm12)}) && $stable(flags);
  endproperty
  a_pc_subtract: assert property (p_pc_subtract) else $error("pc subtract wrong");

endmodule
`default_nettype wire

// ---- design/sdalu_pkg.sv ----
// Purpose: shared constants and types for the standard data-processing datapath
// Assumes: 32-bit data, sixteen destination registers
// Notes: flags are held as a 4-bit vector, negative in the top bit
package sdalu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned IMM12_W = 12;
  localparam int unsigned IMM16_W = 16;
  localparam int unsigned AMT_W = 5;
  localparam int unsigned DEST_W = 4;
  localparam int unsigned FLAG_W = 4;

  // flag vector bit positions
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // pc seen by a pc-relative address is the instruction address plus one word, aligned
  localparam logic [31:0] PC_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffc;

  // shift amount coding: a zero field means 32 for right shifts, extend for rotate
  localparam logic [4:0] AMT_ZERO = 5'h00;
  localparam logic [5:0] FULL_SHIFT = 6'h20;

  // modified immediate field layout
  localparam int unsigned MIMM_MODE_HI = 11;
  localparam int unsigned MIMM_MODE_LO = 10;
  localparam int unsigned MIMM_SPLAT_HI = 9;
  localparam int unsigned MIMM_SPLAT_LO = 8;
  localparam int unsigned MIMM_ROT_HI = 11;
  localparam int unsigned MIMM_ROT_LO = 7;
  localparam int unsigned MIMM_BYTE_HI = 7;
  localparam int unsigned MIMM_FRAC_HI = 6;
  localparam logic [1:0] MIMM_MODE_SPLAT = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [4:0] {
    OP_BITWISE_AND = 5'h00,
    OP_BIT_CLEAR = 5'h01,
    OP_EXCLUSIVE_OR = 5'h02,
    OP_BITWISE_OR = 5'h03,
    OP_OR_NOT = 5'h04,
    OP_ADD = 5'h05,
    OP_ADD_WITH_CARRY = 5'h06,
    OP_SUBTRACT = 5'h07,
    OP_SUBTRACT_WITH_CARRY = 5'h08,
    OP_REVERSE_SUBTRACT = 5'h09,
    OP_COMPARE_NEGATIVE = 5'h0a,
    OP_COMPARE = 5'h0b,
    OP_TEST_EQUIVALENCE = 5'h0c,
    OP_TEST_BITS = 5'h0d,
    OP_COPY_TO_DESTINATION = 5'h0e,
    OP_BITWISE_NOT = 5'h0f,
    OP_PC_RELATIVE = 5'h10
  } sdalu_op_t;

  typedef enum logic [1:0] {
    SRC_SHIFTED_REG = 2'h0,
    SRC_MODIFIED_IMM = 2'h1,
    SRC_PLAIN_IMM12 = 2'h2,
    SRC_PLAIN_IMM16 = 2'h3
  } sdalu_src_t;

  typedef enum logic [1:0] {
    SH_LOGICAL_SHIFT_LEFT = 2'h0,
    SH_LOGICAL_SHIFT_RIGHT = 2'h1,
    SH_ARITHMETIC_SHIFT_RIGHT = 2'h2,
    SH_ROTATE_RIGHT = 2'h3
  } sdalu_shift_t;

endpackage

// ---- design/sdalu_shifter.sv ----
// Purpose: constant-amount shifter for the register second operand
// Assumes: amount field is an instruction constant, never a register value
// Notes: a zero amount means 32 for right shifts and extend for rotate
`timescale 1ns/1ps
`default_nettype none
module sdalu_shifter (
  input wire logic [31:0] value,
  input wire sdalu_pkg::sdalu_shift_t shift_type,
  input wire logic [4:0] amount,
  input wire logic carry_in,
  output logic [31:0] shifted,
  output logic carry_out
);

  logic [5:0] amt;
  logic [32:0] wide;

  // 33-bit working value keeps the last bit shifted out as the carry
  always_comb begin
    amt = (amount == sdalu_pkg::AMT_ZERO) ? sdalu_pkg::FULL_SHIFT : {1'b0, amount};
    wide = '0;
    shifted = value;
    carry_out = carry_in;
    case (shift_type)
      sdalu_pkg::SH_LOGICAL_SHIFT_LEFT: begin
        if (amount != sdalu_pkg::AMT_ZERO) begin
          wide = {1'b0, value} << amount;
          shifted = wide[31:0];
          carry_out = wide[32];
        end
      end
      sdalu_pkg::SH_LOGICAL_SHIFT_RIGHT: begin
        wide = {value, 1'b0} >> amt;
        shifted = wide[32:1];
        carry_out = wide[0];
      end
      sdalu_pkg::SH_ARITHMETIC_SHIFT_RIGHT: begin
        wide = 33'($signed({value, 1'b0}) >>> amt);
        shifted = wide[32:1];
        carry_out = wide[0];
      end
      sdalu_pkg::SH_ROTATE_RIGHT: begin
        if (amount == sdalu_pkg::AMT_ZERO) begin
          // extend form: old carry enters at the top
          shifted = {carry_in, value[31:1]};
          carry_out = value[0];
        end else begin
          shifted = (value >> amount) | (value << 6'(sdalu_pkg::FULL_SHIFT - amt));
          carry_out = shifted[31];
        end
      end
      default: begin
        shifted = value;
        carry_out = carry_in;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- design/sdalu_immexp.sv ----
// Purpose: immediate second operand forms
// Assumes: only the immediate source kinds are read from its outputs
// Notes: rotated constants report their top bit as carry
`timescale 1ns/1ps
`default_nettype none
module sdalu_immexp (
  input wire logic [11:0] imm12,
  input wire logic [15:0] imm16,
  input wire sdalu_pkg::sdalu_src_t src,
  input wire logic carry_in,
  output logic [31:0] imm_value,
  output logic imm_carry
);

  logic [7:0] b;
  logic [31:0] base;
  logic [4:0] rot;

  // modified constant: byte splat patterns or a rotated 8-bit value
  always_comb begin
    b = imm12[sdalu_pkg::MIMM_BYTE_HI:0];
    base = {{(sdalu_pkg::DATA_W - 8){1'b0}}, 1'b1, imm12[sdalu_pkg::MIMM_FRAC_HI:0]};
    rot = imm12[sdalu_pkg::MIMM_ROT_HI:sdalu_pkg::MIMM_ROT_LO];
    imm_value = '0;
    imm_carry = carry_in;
    case (src)
      sdalu_pkg::SRC_MODIFIED_IMM: begin
        if (imm12[sdalu_pkg::MIMM_MODE_HI:sdalu_pkg::MIMM_MODE_LO] == sdalu_pkg::MIMM_MODE_SPLAT) begin
          case (imm12[sdalu_pkg::MIMM_SPLAT_HI:sdalu_pkg::MIMM_SPLAT_LO])
            2'h0: imm_value = {sdalu_pkg::BYTE_ZERO, sdalu_pkg::BYTE_ZERO, sdalu_pkg::BYTE_ZERO, b};
            2'h1: imm_value = {sdalu_pkg::BYTE_ZERO, b, sdalu_pkg::BYTE_ZERO, b};
            2'h2: imm_value = {b, sdalu_pkg::BYTE_ZERO, b, sdalu_pkg::BYTE_ZERO};
            default: imm_value = {b, b, b, b};
          endcase
        end else begin
          // rotation is at least 8 here, so the left term never shifts by 32
          imm_value = (base >> rot) | (base << (5'(sdalu_pkg::FULL_SHIFT) - rot));
          imm_carry = imm_value[31];
        end
      end
      sdalu_pkg::SRC_PLAIN_IMM12:
        imm_value = {{(sdalu_pkg::DATA_W - sdalu_pkg::IMM12_W){1'b0}}, imm12};
      sdalu_pkg::SRC_PLAIN_IMM16:
        imm_value = {{(sdalu_pkg::DATA_W - sdalu_pkg::IMM16_W){1'b0}}, imm16};
      default: imm_value = '0;
    endcase
  end

endmodule
`default_nettype wire

// ---- bench/sdalu_decoder_model.sv ----
// Purpose: decoder and register file stand-in that issues one operation
// Assumes: inputs change on the falling edge and are held over the taking edge
// Notes: instruction address and pc direction share operand values to save ports
`timescale 1ns/1ps
`default_nettype none
module sdalu_decoder_model (
  input wire logic clk,
  output logic issue_valid,
  output var sdalu_pkg::sdalu_op_t op,
  output logic set_flags,
  output var sdalu_pkg::sdalu_src_t src,
  output var sdalu_pkg::sdalu_shift_t shift_type,
  output logic [4:0] shift_amount,
  output logic [11:0] imm12,
  output logic [15:0] imm16,
  output logic pc_subtract,
  output logic [3:0] dest_index,
  output logic [31:0] first_operand_register,
  output logic [31:0] second_operand_register,
  output logic [31:0] instr_address
);
  // idle values at time zero
  initial begin
    issue_valid = 1'b0;
    issue(sdalu_pkg::OP_ADD, 1'b0, sdalu_pkg::SRC_SHIFTED_REG, sdalu_pkg::SH_LOGICAL_SHIFT_LEFT,
      5'h00, 12'h000, 32'h0, 32'h0, 1'b0);
  end

  // one issue cycle; once dropped the register operands, address and imm12 turn to garbage, imm16 stays as issued
  task automatic issue(input sdalu_pkg::sdalu_op_t o, input logic sf,
    input sdalu_pkg::sdalu_src_t s, input sdalu_pkg::sdalu_shift_t t, input logic [4:0] amt,
    input logic [11:0] im, input logic [31:0] a, input logic [31:0] b, input logic go);
    op = o;
    set_flags = sf;
    src = s;
    shift_type = t;
    shift_amount = amt;
    imm12 = im;
    imm16 = {im, 4'hf};
    pc_subtract = a[0];
    dest_index = o[3:0];
    first_operand_register = a;
    second_operand_register = b;
    instr_address = b;
    issue_valid = go;
    if (go) begin
      @(negedge clk);
      issue_valid = 1'b0;
      first_operand_register = ~a;
      second_operand_register = ~b;
      instr_address = ~b;
      imm12 = ~im;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/standard_data_processing_alu_tb.sv ----
// Purpose: self-checking bench for the data-processing execute stage
// Assumes: answer registered on the taking edge, sampled at the next falling edge
// Notes: expected flags are tracked by hand from scenario to scenario
`timescale 1ns/1ps
`default_nettype none
module standard_data_processing_alu_tb;
  localparam sdalu_pkg::sdalu_src_t SR = sdalu_pkg::SRC_SHIFTED_REG;
  localparam sdalu_pkg::sdalu_src_t MI = sdalu_pkg::SRC_MODIFIED_IMM;
  localparam sdalu_pkg::sdalu_src_t P12 = sdalu_pkg::SRC_PLAIN_IMM12;
  localparam sdalu_pkg::sdalu_src_t P16 = sdalu_pkg::SRC_PLAIN_IMM16;
  localparam sdalu_pkg::sdalu_shift_t HL = sdalu_pkg::SH_LOGICAL_SHIFT_LEFT;
  localparam sdalu_pkg::sdalu_shift_t HR = sdalu_pkg::SH_LOGICAL_SHIFT_RIGHT;
  localparam sdalu_pkg::sdalu_shift_t HA = sdalu_pkg::SH_ARITHMETIC_SHIFT_RIGHT;
  localparam sdalu_pkg::sdalu_shift_t HO = sdalu_pkg::SH_ROTATE_RIGHT;
  localparam sdalu_pkg::sdalu_op_t CP = sdalu_pkg::OP_COPY_TO_DESTINATION;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic issue_valid, set_flags, pc_subtract, result_valid, dest_write;
  sdalu_pkg::sdalu_op_t op;
  sdalu_pkg::sdalu_src_t src;
  sdalu_pkg::sdalu_shift_t shift_type;
  logic [4:0] shift_amount;
  logic [11:0] imm12;
  logic [15:0] imm16;
  logic [3:0] dest_index, dest_out, flags;
  logic [31:0] first_operand_register, second_operand_register, instr_address, result;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  sdalu_decoder_model m (.clk(clk), .issue_valid(issue_valid), .op(op), .set_flags(set_flags),
    .src(src), .shift_type(shift_type), .shift_amount(shift_amount), .imm12(imm12),
    .imm16(imm16), .pc_subtract(pc_subtract), .dest_index(dest_index),
    .first_operand_register(first_operand_register),
    .second_operand_register(second_operand_register), .instr_address(instr_address));
  sdalu_core uut (.clk(clk), .resetn(resetn), .issue_valid(issue_valid), .op(op),
    .set_flags(set_flags), .src(src), .shift_type(shift_type), .shift_amount(shift_amount),
    .imm12(imm12), .imm16(imm16), .pc_subtract(pc_subtract), .dest_index(dest_index),
    .first_operand_register(first_operand_register),
    .second_operand_register(second_operand_register), .instr_address(instr_address),
    .result_valid(result_valid), .result(result), .dest_write(dest_write),
    .dest_out(dest_out), .flags(flags));

  always #2.5 clk = ~clk;

  // hang guard: the whole sequence needs about 85 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // issue one op, then judge the registered answer at the following falling edge
  task automatic run(input sdalu_pkg::sdalu_op_t o, input logic sf, input sdalu_pkg::sdalu_src_t s,
    input sdalu_pkg::sdalu_shift_t t, input logic [4:0] amt, input logic [11:0] im,
    input logic [31:0] a, input logic [31:0] b, input logic [31:0] r, input logic we,
    input logic [3:0] fl);
    @(negedge clk);
    m.issue(o, sf, s, t, amt, im, a, b, 1'b1);
    chk("valid", {31'h0, result_valid}, 32'h1);
    chk("result", result, r);
    chk("write", {31'h0, dest_write}, {31'h0, we});
    chk("dest", {28'h0, dest_out}, {28'h0, o[3:0]});
    chk("flags", {28'h0, flags}, {28'h0, fl});
  endtask

  task automatic s_zero();
    chk("rst valid", {31'h0, result_valid}, 32'h0);
    chk("rst result", result, 32'h0);
    chk("rst flags", {28'h0, flags}, 32'h0);
  endtask

  task automatic s_add();
    run(sdalu_pkg::OP_ADD, 1, P12, HL, 0, 12'h005, 10, 0, 15, 1, 4'h0);
    run(sdalu_pkg::OP_SUBTRACT, 1, P12, HL, 0, 12'h005, 5, 0, 0, 1, 4'h6);
    run(sdalu_pkg::OP_ADD, 0, P12, HL, 0, 12'h001, 1, 0, 2, 1, 4'h6);
    @(negedge clk);
    chk("idle valid", {31'h0, result_valid}, 32'h0);
    chk("idle result", result, 32'h2);
  endtask

  task automatic s_cmp();
    run(sdalu_pkg::OP_COMPARE, 0, SR, HL, 0, 0, 3, 5, 32'hffff_fffe, 0, 4'h8);
    run(sdalu_pkg::OP_COMPARE_NEGATIVE, 0, SR, HL, 0, 0, 32'hffff_ffff, 1, 0, 0, 4'h6);
    run(sdalu_pkg::OP_COMPARE, 0, SR, HL, 0, 0, 32'h8000_0000, 1, 32'h7fff_ffff, 0, 4'h3);
  endtask

  // carry variants with the carry flag set, then clear
  task automatic s_carry();
    run(sdalu_pkg::OP_ADD_WITH_CARRY, 0, SR, HL, 0, 0, 1, 2, 4, 1, 4'h3);
    run(sdalu_pkg::OP_SUBTRACT_WITH_CARRY, 0, SR, HL, 0, 0, 10, 3, 7, 1, 4'h3);
    run(sdalu_pkg::OP_COMPARE, 0, SR, HL, 0, 0, 3, 5, 32'hffff_fffe, 0, 4'h8);
    run(sdalu_pkg::OP_ADD_WITH_CARRY, 0, SR, HL, 0, 0, 1, 2, 3, 1, 4'h8);
    run(sdalu_pkg::OP_SUBTRACT_WITH_CARRY, 0, SR, HL, 0, 0, 10, 3, 6, 1, 4'h8);
  endtask

  task automatic s_logic();
    sdalu_pkg::sdalu_op_t ops[7] = '{sdalu_pkg::OP_BITWISE_AND, sdalu_pkg::OP_BIT_CLEAR,
      sdalu_pkg::OP_EXCLUSIVE_OR, sdalu_pkg::OP_BITWISE_OR, sdalu_pkg::OP_OR_NOT,
      sdalu_pkg::OP_BITWISE_NOT, sdalu_pkg::OP_REVERSE_SUBTRACT};
    logic [31:0] ex[7] = '{32'hf000_1200, 32'h00f0_0034, 32'h0ff0_ed34, 32'hfff0_ff34,
      32'hf0ff_12ff, 32'h00ff_00ff, 32'h0e10_eccc};
    for (int i = 0; i < 7; i++) begin
      run(ops[i], 0, SR, HL, 0, 0, 32'hf0f0_1234, 32'hff00_ff00, ex[i], 1, 4'h8);
    end
    run(sdalu_pkg::OP_TEST_BITS, 0, SR, HL, 0, 0, 32'hf0, 32'h0f, 0, 0, 4'h4);
    run(sdalu_pkg::OP_TEST_EQUIVALENCE, 0, SR, HL, 0, 0, 32'h8000_0000, 0,
      32'h8000_0000, 0, 4'h8);
  endtask

  // a zero amount means 32 for right shifts and extend for rotate
  task automatic s_shift();
    run(CP, 0, SR, HL, 31, 0, 0, 3, 32'h8000_0000, 1, 4'h8);
    run(CP, 0, SR, HR, 0, 0, 0, 32'hffff_ffff, 0, 1, 4'h8);
    run(CP, 0, SR, HR, 1, 0, 0, 32'h8000_0000, 32'h4000_0000, 1, 4'h8);
    run(CP, 0, SR, HA, 0, 0, 0, 32'h8000_0000, 32'hffff_ffff, 1, 4'h8);
    run(CP, 0, SR, HA, 4, 0, 0, 32'h8000_0000, 32'hf800_0000, 1, 4'h8);
    run(CP, 0, SR, HO, 4, 0, 0, 32'h1234_5678, 32'h8123_4567, 1, 4'h8);
    run(CP, 0, SR, HO, 0, 0, 0, 3, 1, 1, 4'h8);
    run(CP, 1, SR, HO, 0, 0, 0, 3, 1, 1, 4'h2);
  endtask

  task automatic s_imm();
    run(CP, 0, MI, HL, 0, 12'h0ab, 0, 0, 32'hab, 1, 4'h2);
    run(CP, 0, MI, HL, 0, 12'h1ab, 0, 0, 32'h00ab_00ab, 1, 4'h2);
    run(CP, 0, MI, HL, 0, 12'h2ab, 0, 0, 32'hab00_ab00, 1, 4'h2);
    run(CP, 0, MI, HL, 0, 12'h3ab, 0, 0, 32'habab_abab, 1, 4'h2);
    run(sdalu_pkg::OP_ADD, 0, MI, HL, 0, 12'h1ab, 1, 0, 32'h00ab_00ac, 1, 4'h2);
    run(CP, 0, P16, HL, 0, 12'hbee, 0, 0, 32'hbeef, 1, 4'h2);
    run(sdalu_pkg::OP_TEST_BITS, 0, P16, HL, 0, 12'h0f0, 32'hffff_0f00, 0, 32'h0f00, 0,
      4'h2);
    run(sdalu_pkg::OP_REVERSE_SUBTRACT, 0, P12, HL, 0, 12'h005, 1, 0, 4, 1, 4'h2);
    run(sdalu_pkg::OP_BITWISE_NOT, 0, MI, HL, 0, 12'h0ab, 0, 0, 32'hffff_ff54, 1,
      4'h2);
    run(CP, 1, MI, HL, 0, 12'h4ff, 0, 0, 32'h7f80_0000, 1, 4'h0);
  endtask

  // operand b doubles as the instruction address, a[0] picks subtraction
  task automatic s_pc();
    run(sdalu_pkg::OP_PC_RELATIVE, 1, P12, HL, 0, 12'h010, 0, 32'h1002, 32'h1014, 1, 4'h0);
    run(sdalu_pkg::OP_PC_RELATIVE, 1, P12, HL, 0, 12'h010, 1, 32'h1002, 32'h0ff4, 1, 4'h0);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reset, all scenarios, then a second reset at the end of the run
  initial begin
    repeat (2) @(negedge clk);
    s_zero();
    resetn = 1'b1;
    s_add();
    s_cmp();
    s_carry();
    s_logic();
    s_shift();
    s_imm();
    s_pc();
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    s_zero();
    end_sim();
  end
endmodule
`default_nettype wire
